// ---- inc/csps_cfg.svh ----
`ifndef CSPS_CFG_SVH
`define CSPS_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets seen on the link.
// ----------------------------------------------------------------------
`define CSPS_ADDR_FLAGS    8'h0C
`define CSPS_ADDR_ENABLES  8'h8C
`define CSPS_ADDR_STATUS   8'h8E
`define CSPS_ADDR_TRIM     8'h90
`define CSPS_ADDR_LOW      8'h02
`define CSPS_ADDR_LATCH    8'h0A

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define CSPS_EE_BIT        7
`define CSPS_AD_BIT        6
`define CSPS_CMP_BIT       3
`define CSPS_TMR_BIT       0
`define CSPS_POR_BIT       1
`define CSPS_BOD_BIT       0
`define CSPS_WB_WRITE_BIT  16
`define CSPS_WB_BOD_BIT    4

// ----------------------------------------------------------------------
// Reset values and fixed addresses.
// ----------------------------------------------------------------------
`define CSPS_TRIM_RESET    6'h20
`define CSPS_VECTOR_ADDR   13'h0004

// ----------------------------------------------------------------------
// Wishbone word offsets of the controller registers.
// ----------------------------------------------------------------------
`define CSPS_WB_CTRL       6'h00
`define CSPS_WB_ACCESS     6'h01
`define CSPS_WB_OP         6'h02
`define CSPS_WB_EVENT      6'h03
`define CSPS_WB_STATUS     6'h04

`endif

// ---- inc/csps_pkg.sv ----
// ----------------------------------------------------------------------
// Shared types.
// ----------------------------------------------------------------------
package csps_pkg;

   // Program flow operation issued by the core for one cycle.
   typedef enum logic [2:0] {
      CSPS_OP_NONE,
      CSPS_OP_STEP,
      CSPS_OP_CALL,
      CSPS_OP_JUMP,
      CSPS_OP_RET,
      CSPS_OP_VECTOR
   } csps_op_t;

endpackage

// ---- inc/csps_link_if.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Link between the core side and the special-function block.
// ----------------------------------------------------------------------
interface csps_link_if;
   logic [7:0]           regAddr;           // Register offset.
   logic [7:0]           regWdata;          // Write data.
   logic                 regWr;             // Write strobe.
   logic                 regRd;             // Read strobe.
   logic [7:0]           regRdata;          // Read data, one cycle later.
   csps_pkg::csps_op_t   op;                // Program flow operation.
   logic [10:0]          operand;           // Call or jump target.
   logic                 eeDone;            // EEPROM write completed.
   logic                 convDone;          // Conversion finished.
   logic                 cmpChange;         // Comparator changed.
   logic                 tmrOvf;            // Timer one overflowed.
   logic                 brownout;          // Brown-out detected.
   logic                 globalIrqEnable;   // Global enable.
   logic                 peripheralIrqGate; // Peripheral gate.
   logic [12:0]          pc;                // Program counter.
   logic                 irqReq;            // Peripheral request.

   modport dev (
      input  regAddr, regWdata, regWr, regRd, op, operand,
      input  eeDone, convDone, cmpChange, tmrOvf, brownout,
      input  globalIrqEnable, peripheralIrqGate,
      output regRdata, pc, irqReq
   );

   modport core (
      output regAddr, regWdata, regWr, regRd, op, operand,
      output eeDone, convDone, cmpChange, tmrOvf, brownout,
      output globalIrqEnable, peripheralIrqGate,
      input  regRdata, pc, irqReq
   );
endinterface

// ---- rtl/csps_return_stack.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Circular return stack with a hidden pointer.
// ----------------------------------------------------------------------
module csps_return_stack #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 13
) (
   input  wire logic             clock,    // Core clock.
   input  wire logic             rstn,     // Asynchronous reset, low.
   input  wire logic             push,     // Store pushData.
   input  wire logic             pop,      // Release the top entry.
   input  wire logic [WIDTH-1:0] pushData, // Value to store.
   output logic      [WIDTH-1:0] popData   // Current top entry.
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] entry [0:DEPTH-1];
   logic [PW-1:0]    pointer;
   wire  [PW-1:0]    topIndex = pointer - PW'(1);

   // The top entry is visible before the pop takes effect.
   assign popData = entry[topIndex];

   // The pointer simply wraps, so a ninth push lands on the first entry.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pointer <= '0;
      end else if (push) begin
         pointer <= pointer + PW'(1);
      end else if (pop) begin
         pointer <= topIndex;
      end
   end

   // Entries hold no reset; only the pointer is control state.
   always_ff @(posedge clock) begin
      if (push) begin
         entry[pointer] <= pushData;
      end
   end
endmodule

// ---- rtl/csps_device_end.sv ----
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "csps_cfg.svh"

// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module csps_device_end (
   input  wire logic    clock,   // Core clock.
   input  wire logic    rstn,    // Asynchronous reset, low.
   csps_link_if.dev     link,    // Link to the core side.
   output logic [5:0]   oscTrim  // Trim value to the oscillator.
);
   localparam int NFLAG = 4;
   localparam int FLAG_POS [0:NFLAG-1] = '{
      `CSPS_EE_BIT, `CSPS_AD_BIT, `CSPS_CMP_BIT, `CSPS_TMR_BIT
   };

   // ----------------------------------------------------------------------
   // Register state.
   // ----------------------------------------------------------------------
   logic [NFLAG-1:0] flag;
   logic [NFLAG-1:0] enable;
   logic             porStatus;
   logic             brownoutStatus;
   logic [4:0]       counterHighLatch;
   logic [12:0]      pc;
   logic [7:0]       regRdata;
   logic             irqReq;

   logic [NFLAG-1:0] next_flag;
   logic [NFLAG-1:0] next_enable;
   logic             next_porStatus;
   logic             next_brownoutStatus;
   logic [4:0]       next_counterHighLatch;
   logic [5:0]       next_oscTrim;
   logic [12:0]      next_pc;
   logic             stackPush;
   logic             stackPop;
   logic [12:0]      stackTop;
   logic [7:0]       flagByte;
   logic [7:0]       enableByte;

   // ----------------------------------------------------------------------
   // Address decode.
   // ----------------------------------------------------------------------
   // Each write strobe is qualified by its own offset.
   wire flagWrite   = link.regWr && (link.regAddr == `CSPS_ADDR_FLAGS);
   wire enableWrite = link.regWr && (link.regAddr == `CSPS_ADDR_ENABLES);
   wire statusWrite = link.regWr && (link.regAddr == `CSPS_ADDR_STATUS);
   wire trimWrite   = link.regWr && (link.regAddr == `CSPS_ADDR_TRIM);
   wire lowWrite    = link.regWr && (link.regAddr == `CSPS_ADDR_LOW);
   wire latchWrite  = link.regWr && (link.regAddr == `CSPS_ADDR_LATCH);

   // Event inputs in flag order: write-done, conversion, comparator, timer.
   wire [NFLAG-1:0] events = {
      link.tmrOvf, link.cmpChange, link.convDone, link.eeDone
   };

   // ----------------------------------------------------------------------
   // Peripheral flags and enables.
   // ----------------------------------------------------------------------
   // An event in the same cycle as a clearing write keeps the flag set.
   for (genvar gi = 0; gi < NFLAG; gi++) begin : g_flag
      assign next_flag[gi] = events[gi] |
         (flagWrite ? link.regWdata[FLAG_POS[gi]] : flag[gi]);
      assign next_enable[gi] = enableWrite ?
         link.regWdata[FLAG_POS[gi]] : enable[gi];
   end

   // Only the four documented positions carry state on readback.
   always_comb begin
      flagByte   = 8'h00;
      enableByte = 8'h00;
      for (int i = 0; i < NFLAG; i++) begin
         flagByte[FLAG_POS[i]]   = flag[i];
         enableByte[FLAG_POS[i]] = enable[i];
      end
   end

   // Flags and enables are cleared at reset.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flag   <= '0;
         enable <= '0;
      end else begin
         flag   <= next_flag;
         enable <= next_enable;
      end
   end

   // ----------------------------------------------------------------------
   // Reset cause and oscillator trim.
   // ----------------------------------------------------------------------
   // Software sets the status bits; a brown-out beats a software write.
   assign next_porStatus = statusWrite ?
      link.regWdata[`CSPS_POR_BIT] : porStatus;
   assign next_brownoutStatus = link.brownout ? 1'b0 :
      (statusWrite ? link.regWdata[`CSPS_BOD_BIT] : brownoutStatus);
   assign next_oscTrim = trimWrite ? link.regWdata[7:2] : oscTrim;

   // The reset input is the power-on reset of this block.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         porStatus      <= 1'b0;
         brownoutStatus <= 1'b0;
         oscTrim        <= `CSPS_TRIM_RESET;
      end else begin
         porStatus      <= next_porStatus;
         brownoutStatus <= next_brownoutStatus;
         oscTrim        <= next_oscTrim;
      end
   end

   // ----------------------------------------------------------------------
   // Program counter and its high latch.
   // ----------------------------------------------------------------------
   // The latch changes only on its own write, never on stack activity.
   assign next_counterHighLatch = latchWrite ?
      link.regWdata[4:0] : counterHighLatch;

   // Flow operations pick the next count; a low-byte write wins over a step.
   always_comb begin
      next_pc   = pc;
      stackPush = 1'b0;
      stackPop  = 1'b0;
      case (link.op)
         csps_pkg::CSPS_OP_STEP: begin
            next_pc = pc + 13'h0001;
         end
         csps_pkg::CSPS_OP_CALL: begin
            next_pc   = {counterHighLatch[4:3], link.operand};
            stackPush = 1'b1;
         end
         csps_pkg::CSPS_OP_JUMP: begin
            next_pc = {counterHighLatch[4:3], link.operand};
         end
         csps_pkg::CSPS_OP_RET: begin
            next_pc  = stackTop;
            stackPop = 1'b1;
         end
         csps_pkg::CSPS_OP_VECTOR: begin
            next_pc   = `CSPS_VECTOR_ADDR;
            stackPush = 1'b1;
         end
         default: begin
            next_pc = pc;
         end
      endcase
      if (lowWrite && (link.op == csps_pkg::CSPS_OP_NONE ||
                       link.op == csps_pkg::CSPS_OP_STEP)) begin
         next_pc = {counterHighLatch, link.regWdata};
      end
   end

   // Any reset clears the counter and the latch.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pc               <= 13'h0000;
         counterHighLatch <= 5'h00;
      end else begin
         pc               <= next_pc;
         counterHighLatch <= next_counterHighLatch;
      end
   end

   // The stack has no status output at all.
   csps_return_stack #(
      .DEPTH (8),
      .WIDTH (13)
   ) u_stack (
      .clock    (clock),
      .rstn     (rstn),
      .push     (stackPush),
      .pop      (stackPop),
      .pushData (pc),
      .popData  (stackTop)
   );

   // ----------------------------------------------------------------------
   // Read path and interrupt request.
   // ----------------------------------------------------------------------
   // The upper counter bits have no read path; unmapped offsets read zero.
   wire [7:0] readByte =
      (link.regAddr == `CSPS_ADDR_FLAGS)   ? flagByte :
      (link.regAddr == `CSPS_ADDR_ENABLES) ? enableByte :
      (link.regAddr == `CSPS_ADDR_STATUS)  ?
         {6'h00, porStatus, brownoutStatus} :
      (link.regAddr == `CSPS_ADDR_TRIM)    ? {oscTrim, 2'b00} :
      (link.regAddr == `CSPS_ADDR_LOW)     ? pc[7:0] :
      (link.regAddr == `CSPS_ADDR_LATCH)   ? {3'h0, counterHighLatch} :
      8'h00;

   // Masked flags are ORed, then need both the gate and the global enable.
   wire irqRaw = |(flag & enable);
   wire next_irqReq = irqRaw && link.peripheralIrqGate &&
      link.globalIrqEnable;

   // Read data is captured on the read strobe and held afterwards.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         regRdata <= 8'h00;
         irqReq   <= 1'b0;
      end else begin
         regRdata <= link.regRd ? readByte : regRdata;
         irqReq   <= next_irqReq;
      end
   end

   assign link.regRdata = regRdata;
   assign link.pc       = pc;
   assign link.irqReq   = irqReq;
endmodule

// ---- rtl/csps_core_end.sv ----
`timescale 1ns/1ps
`include "csps_cfg.svh"

// ----------------------------------------------------------------------
// Core-side stand-in driven from a classic Wishbone slave.
// ----------------------------------------------------------------------
module csps_core_end #(
   parameter int ADR_W = 8
) (
   input  wire logic             clock,  // Core clock.
   input  wire logic             rstn,   // Asynchronous reset, low.
   input  wire logic             cyc_i,  // Bus cycle.
   input  wire logic             stb_i,  // Strobe.
   input  wire logic             we_i,   // Write enable.
   input  wire logic [ADR_W-1:0] adr_i,  // Byte address.
   input  wire logic [3:0]       sel_i,  // Byte selects.
   input  wire logic [31:0]      dat_i,  // Write data.
   output logic      [31:0]      dat_o,  // Read data.
   output logic                  ack_o,  // Acknowledge.
   csps_link_if.core             link    // Link to the device side.
);
   logic [1:0]               ctrl;
   logic [7:0]               regAddr;
   logic [7:0]               regWdata;
   logic                     regWr;
   logic                     regRd;
   logic                     rdPending;
   logic [7:0]               lastRead;
   csps_pkg::csps_op_t       op;
   logic [10:0]              operand;
   logic [4:0]               eventPulse;

   // ----------------------------------------------------------------------
   // Bus decode.
   // ----------------------------------------------------------------------
   // A request is taken once; the write lands when ack is seen.
   wire       take      = cyc_i && stb_i && !ack_o;
   wire       commit    = cyc_i && stb_i && ack_o && we_i && (sel_i == 4'hF);
   wire [5:0] wordIndex = adr_i[7:2];
   wire       hitCtrl   = commit && (wordIndex == `CSPS_WB_CTRL);
   wire       hitAccess = commit && (wordIndex == `CSPS_WB_ACCESS);
   wire       hitOp     = commit && (wordIndex == `CSPS_WB_OP);
   wire       hitEvent  = commit && (wordIndex == `CSPS_WB_EVENT);
   wire       accessWr  = dat_i[`CSPS_WB_WRITE_BIT];

   // Unmapped words read zero and are still acknowledged.
   wire [31:0] readWord =
      (wordIndex == `CSPS_WB_CTRL)   ? {30'h0, ctrl} :
      (wordIndex == `CSPS_WB_ACCESS) ? {24'h0, lastRead} :
      (wordIndex == `CSPS_WB_STATUS) ? {18'h0, link.irqReq, link.pc} :
      32'h0000_0000;

   // Acknowledge one cycle after the request, then drop it.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= take;
         dat_o <= take ? readWord : dat_o;
      end
   end

   // ----------------------------------------------------------------------
   // Link drivers.
   // ----------------------------------------------------------------------
   // Control bits hold; strobes and operations last one cycle.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl       <= 2'b00;
         regAddr    <= 8'h00;
         regWdata   <= 8'h00;
         regWr      <= 1'b0;
         regRd      <= 1'b0;
         op         <= csps_pkg::CSPS_OP_NONE;
         operand    <= 11'h000;
         eventPulse <= 5'h00;
      end else begin
         ctrl       <= hitCtrl ? dat_i[1:0] : ctrl;
         regAddr    <= hitAccess ? dat_i[15:8] : regAddr;
         regWdata   <= hitAccess ? dat_i[7:0] : regWdata;
         regWr      <= hitAccess && accessWr;
         regRd      <= hitAccess && !accessWr;
         op         <= hitOp ? csps_pkg::csps_op_t'(dat_i[14:12])
                             : csps_pkg::CSPS_OP_NONE;
         operand    <= hitOp ? dat_i[10:0] : operand;
         eventPulse <= hitEvent ? dat_i[4:0] : 5'h00;
      end
   end

   // Read data from the device arrives one cycle after the read strobe.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdPending <= 1'b0;
         lastRead  <= 8'h00;
      end else begin
         rdPending <= regRd;
         lastRead  <= rdPending ? link.regRdata : lastRead;
      end
   end

   assign link.globalIrqEnable   = ctrl[0];
   assign link.peripheralIrqGate = ctrl[1];
   assign link.regAddr           = regAddr;
   assign link.regWdata          = regWdata;
   assign link.regWr             = regWr;
   assign link.regRd             = regRd;
   assign link.op                = op;
   assign link.operand           = operand;
   assign link.eeDone            = eventPulse[0];
   assign link.convDone          = eventPulse[1];
   assign link.cmpChange         = eventPulse[2];
   assign link.tmrOvf            = eventPulse[3];
   assign link.brownout          = eventPulse[`CSPS_WB_BOD_BIT];
endmodule

// ---- test/csps_assertions.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Link checks between the core end and the device end.
// ----------------------------------------------------------------------
module csps_assertions (
   input wire logic               clock,             // Core clock.
   input wire logic               rstn,              // Reset, low.
   input wire logic [7:0]         regAddr,           // Offset.
   input wire logic [7:0]         regWdata,          // Write data.
   input wire logic               regWr,             // Write strobe.
   input wire logic               regRd,             // Read strobe.
   input wire logic [7:0]         regRdata,          // Read data.
   input csps_pkg::csps_op_t      op,                // Flow operation.
   input wire logic [10:0]        operand,           // Target.
   input wire logic               globalIrqEnable,   // Global enable.
   input wire logic               peripheralIrqGate, // Gate.
   input wire logic [12:0]        pc,                // Counter.
   input wire logic               irqReq             // Request.
);
   logic [4:0]  latchCopy; // Shadow of the high latch.
   logic [12:0] pushedPc;  // Last value pushed.
   logic        callTop;   // A push is on top.
   logic        lowWr;     // Low byte written.

   // Shadows of the latch and of the newest push.
   assign lowWr = regWr && regAddr == 8'h02;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         latchCopy <= 5'h00;
         pushedPc <= 13'h0000;
         callTop <= 1'b0;
      end else begin
         if (regWr && regAddr == 8'h0A) latchCopy <= regWdata[4:0];
         if (op == csps_pkg::CSPS_OP_CALL || op == csps_pkg::CSPS_OP_VECTOR)
            pushedPc <= pc;
         callTop <= (op == csps_pkg::CSPS_OP_RET) ? 1'b0 :
            (op == csps_pkg::CSPS_OP_CALL || op == csps_pkg::CSPS_OP_VECTOR)
            | callTop;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   property p_jump;
      op == csps_pkg::CSPS_OP_JUMP |=>
         pc == {$past(latchCopy[4:3]), $past(operand)};
   endproperty
   a_jump: assert property (p_jump)
      else $error("jump target wrong");
   property p_step;
      op == csps_pkg::CSPS_OP_STEP && !lowWr |=> pc == $past(pc) + 13'h0001;
   endproperty
   a_step: assert property (p_step)
      else $error("step did not advance");
   property p_lowwr;
      lowWr && op inside {csps_pkg::CSPS_OP_NONE, csps_pkg::CSPS_OP_STEP}
         |=> pc == {$past(latchCopy), $past(regWdata)};
   endproperty
   a_lowwr: assert property (p_lowwr)
      else $error("low write load wrong");
   property p_vector;
      op == csps_pkg::CSPS_OP_VECTOR |=> pc == 13'h0004;
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector address wrong");
   property p_hold;
      op == csps_pkg::CSPS_OP_NONE && !lowWr |=> $stable(pc);
   endproperty
   a_hold: assert property (p_hold)
      else $error("counter moved while idle");
   property p_ret;
      op == csps_pkg::CSPS_OP_RET && callTop |=> pc == $past(pushedPc);
   endproperty
   a_ret: assert property (p_ret)
      else $error("return value wrong");
   property p_gate;
      !peripheralIrqGate |=> !irqReq;
   endproperty
   a_gate: assert property (p_gate)
      else $error("request without gate");
   property p_global;
      !globalIrqEnable |=> !irqReq;
   endproperty
   a_global: assert property (p_global)
      else $error("request without global enable");
   property p_unused;
      regRd && (regAddr == 8'h0C || regAddr == 8'h8C)
         |=> (regRdata & 8'h36) == 8'h00;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused bits set");
endmodule

// ---- test/core_sfr_pc_stack_test.sv ----
`timescale 1ns/1ps

module core_sfr_pc_stack_test;
   logic        clock, rstn, cyc, stb, we, ack;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   logic [5:0]  oscTrim;
   int          fail_count, checked;

   csps_link_if link();
   csps_core_end u_csps_core_end (.clock(clock), .rstn(rstn), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .link(link));
   csps_device_end u_csps_device_end (.clock(clock), .rstn(rstn),
      .link(link), .oscTrim(oscTrim));
   csps_assertions u_csps_assertions (.clock(clock), .rstn(rstn),
      .regAddr(link.regAddr), .regWdata(link.regWdata), .regWr(link.regWr),
      .regRd(link.regRd), .regRdata(link.regRdata), .op(link.op),
      .operand(link.operand), .globalIrqEnable(link.globalIrqEnable),
      .peripheralIrqGate(link.peripheralIrqGate), .pc(link.pc),
      .irqReq(link.irqReq));

   // The clock toggles every half period.
   always #50 clock = ~clock;

   // Closing report.
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Compare one value and count it.
   task automatic chk(input string s, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", s, e, g);
         fail_count++;
      end
   endtask

   // One classic bus cycle, held until ack is sampled.
   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
      int n;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 64);
      r = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 64) begin
         fail_count++;
         test_done();
      end
      @(posedge clock);
   endtask

   // Device register write and read over the access register.
   task automatic dw(input logic [7:0] a, d);
      wb(8'h04, 1'b1, {15'h0000, 1'b1, a, d}, q);
   endtask
   task automatic dr(input logic [7:0] a, e, input string s);
      wb(8'h04, 1'b1, {15'h0000, 1'b0, a, 8'h00}, q);
      @(posedge clock);
      wb(8'h04, 1'b0, 32'h00000000, q);
      chk(s, e, q[7:0]);
   endtask
   task automatic op(input csps_pkg::csps_op_t o, input logic [10:0] t);
      wb(8'h08, 1'b1, {17'h00000, o, 1'b0, t}, q);
   endtask
   task automatic st(input logic [12:0] p, input logic i);
      @(posedge clock); // The request lags its flag or enable by one edge.
      wb(8'h10, 1'b0, 32'h00000000, q);
      chk("pc", p, q[12:0]);
      chk("irq", i, q[13]);
   endtask

   // Reset values of the enables, flags, status, trim and counter.
   task automatic t_reset;
      dr(8'h8C, 8'h00, "enables");
      dr(8'h0C, 8'h00, "flags");
      dr(8'h8E, 8'h00, "status");
      dr(8'h90, 8'h80, "trim");
      chk("osc", 6'h20, oscTrim);
      st(13'h0000, 1'b0);
   endtask

   // Writable bits, unused bits and unmapped places.
   task automatic t_regs;
      dw(8'h8C, 8'hFF);
      dr(8'h8C, 8'hC9, "enables");
      dw(8'h90, 8'hFF);
      dr(8'h90, 8'hFC, "trim");
      chk("osc", 6'h3F, oscTrim);
      dw(8'h8E, 8'hFF);
      dr(8'h8E, 8'h03, "status");
      dr(8'h55, 8'h00, "unmapped");
      wb(8'h3C, 1'b0, 32'h00000000, q);
      chk("bus unmapped", 32'h00000000, q);
      dw(8'h8C, 8'h00);
   endtask

   // Events set sticky flags; request follows the gates.
   task automatic t_flags;
      logic [7:0] fb [4] = '{8'h80, 8'h40, 8'h08, 8'h01};
      logic [7:0] acc;
      acc = 8'h00;
      wb(8'h00, 1'b1, 32'h00000003, q);
      for (int i = 0; i < 4; i++) begin
         wb(8'h0C, 1'b1, 32'h1 << i, q);
         acc = acc | fb[i];
         dr(8'h0C, acc, "flags");
      end
      st(13'h0000, 1'b0);
      dw(8'h8C, 8'h01);
      st(13'h0000, 1'b1);
      wb(8'h00, 1'b1, 32'h00000001, q);
      st(13'h0000, 1'b0);
      wb(8'h00, 1'b1, 32'h00000002, q);
      wb(8'h00, 1'b0, 32'h00000000, q);
      chk("ctrl", 32'h00000002, q);
      st(13'h0000, 1'b0);
      wb(8'h00, 1'b1, 32'h00000003, q);
      dr(8'h0C, 8'hC9, "flags");
      dw(8'h0C, 8'h00);
      st(13'h0000, 1'b0);
      wb(8'h0C, 1'b1, 32'h00000010, q);
      dr(8'h8E, 8'h02, "status");
   endtask

   // Counter loads, calls, vector and returns.
   task automatic t_pc;
      dw(8'h0A, 8'h1F);
      dw(8'h02, 8'h34);
      st(13'h1F34, 1'b0);
      dr(8'h02, 8'h34, "low byte");
      op(csps_pkg::CSPS_OP_JUMP, 11'h123);
      st(13'h1923, 1'b0);
      op(csps_pkg::CSPS_OP_STEP, 11'h000);
      op(csps_pkg::CSPS_OP_CALL, 11'h7FF);
      st(13'h1FFF, 1'b0);
      op(csps_pkg::CSPS_OP_VECTOR, 11'h000);
      st(13'h0004, 1'b0);
      op(csps_pkg::CSPS_OP_RET, 11'h000);
      op(csps_pkg::CSPS_OP_RET, 11'h000);
      st(13'h1924, 1'b0);
      dr(8'h0A, 8'h1F, "latch");
   endtask

   // Nine pushes wrap over the first entry.
   task automatic t_wrap;
      dw(8'h0A, 8'h00);
      for (int i = 1; i < 10; i++) begin
         op(csps_pkg::CSPS_OP_JUMP, 11'(i));
         op(csps_pkg::CSPS_OP_CALL, 11'h700);
      end
      for (int i = 9; i > 1; i--) begin
         op(csps_pkg::CSPS_OP_RET, 11'h000);
         st(13'(i), 1'b0);
      end
      op(csps_pkg::CSPS_OP_RET, 11'h000);
      st(13'h0009, 1'b0);
   endtask

   // Main sequence.
   initial begin
      clock = 1'b0; rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
      adr = 8'h00; sel = 4'h0; wdat = 32'h00000000;
      fail_count = 0; checked = 0;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      t_reset();
      t_regs();
      t_flags();
      t_pc();
      t_wrap();
      test_done();
   end
endmodule
